//--- pkg/sccr_pkg.sv
// How it works
// - Resume tone wakes without reset, self-clears
// - Writing one enters shutdown, reads zero
// - Writing one enters sleep from active mode, reads zero
// - Soft reset restores registers to defaults
// - Address enable; GPIO addressing loads address status
// - Manual bit hands chain enables to register
// - Balancing start samples configuration, self-clears
// - Temperature comparator configuration locked while enabled
// - Voltage comparator configuration locked while enabled
// - Auxiliary start samples all converter configuration
// - Cell start samples cell converter configuration
package sccr_pkg;
	localparam int SCCR_ADDR_W = 12;
	localparam int SCCR_DATA_W = 8;
	localparam int SCCR_ADDR_BITS = 6;
	localparam int SCCR_CHAIN_W = 4;
	localparam int SCCR_NUM_CFG = 5;
	// Register offsets
	localparam logic [11:0] SCCR_OFS_STACK_CMD = 12'h105;
	localparam logic [11:0] SCCR_OFS_MEAS_CTRL = 12'h106;
	localparam logic [11:0] SCCR_OFS_CHAIN_MAN = 12'h110;
	localparam logic [11:0] SCCR_OFS_ADDR_CFG = 12'h111;
	localparam logic [11:0] SCCR_OFS_ADDR_STAT = 12'h112;
	localparam logic [11:0] SCCR_OFS_MODE_STAT = 12'h113;
	localparam logic [11:0] SCCR_OFS_CFG_BASE = 12'h114;
	// Stack command control fields
	localparam int SCCR_B_DIR = 7;
	localparam int SCCR_B_SHUT_TONE = 6;
	localparam int SCCR_B_WAKE_TONE = 5;
	localparam int SCCR_B_RESUME_TONE = 4;
	localparam int SCCR_B_ENTER_SHUT = 3;
	localparam int SCCR_B_ENTER_SLEEP = 2;
	localparam int SCCR_B_SOFT_RST = 1;
	localparam int SCCR_B_ADDR_EN = 0;
	// Measure and protect control fields
	localparam int SCCR_B_TEMP_OUT = 7;
	localparam int SCCR_B_CHAIN_MAN = 6;
	localparam int SCCR_B_BALANCING_START = 5;
	localparam int SCCR_B_TSREF = 4;
	localparam int SCCR_B_TEMP_CMP = 3;
	localparam int SCCR_B_VOLT_CMP = 2;
	localparam int SCCR_B_AUX_GO = 1;
	localparam int SCCR_B_CELL_GO = 0;
	// Snapshot slots
	localparam int SCCR_CFG_BAL = 0;
	localparam int SCCR_CFG_TEMP = 1;
	localparam int SCCR_CFG_VOLT = 2;
	localparam int SCCR_CFG_AUX = 3;
	localparam int SCCR_CFG_CELL = 4;
	// Other fields
	localparam int SCCR_B_GPIO_ADDR_SEL = 0;
	localparam int SCCR_B_ADDR_ARMED = 6;
	localparam int SCCR_B_RX_SETTLED = 3;
	// Receiver enables inside the chain enable word
	localparam int SCCR_B_UPPER_RX = 2;
	localparam int SCCR_B_LOWER_RX = 0;
	// Stored bits of the stack command and measure and protect registers; the rest are self-clearing
	localparam logic [7:0] SCCR_STACK_CMD_KEEP = 8'h80;
	localparam logic [7:0] SCCR_MEAS_CTRL_KEEP = 8'hDC;
	localparam logic [7:0] SCCR_RST_REG = 8'h00;
	localparam logic [7:0] SCCR_RD_UNMAPPED = 8'h00;
	// Receiver settle time
	localparam int SCCR_RX_SETTLE_US = 100;
	localparam int SCCR_CLK_MHZ = 200;
	localparam int SCCR_RX_SETTLE_CYC = SCCR_RX_SETTLE_US * SCCR_CLK_MHZ;
	typedef enum logic [2:0] {
		SCCR_ACTIVE = 3'h1,
		SCCR_SLEEP = 3'h2,
		SCCR_SHUTDOWN = 3'h4
	} sccr_mode_t;
endpackage : sccr_pkg

//--- pkg/sccr_snap_if.sv
`timescale 1ns/1ps
`default_nettype none
// Live configuration in, sampled copies out
interface sccr_snap_if #(
	parameter int N = 5,
	parameter int W = 8
);
	logic [N-1:0] capture;
	logic clear;
	logic [N-1:0][W-1:0] live;
	logic [N-1:0][W-1:0] active;
	modport ctrl (output capture, output clear, output live, input active);
	modport snap (input capture, input clear, input live, output active);
endinterface : sccr_snap_if
`default_nettype wire

//--- hw/sccr_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sccr_pin_sync #(
	parameter int W = 6
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Pins and filtered result
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinStable
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// Three-stage chain; only stage two reads stage one
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A bit changes only when the last two stages agree, filtering glitches
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					pinStable[i] <= 1'b0;
				end else if (stage2[i] == stage3[i]) begin
					pinStable[i] <= stage3[i];
				end
			end
		end
	endgenerate
endmodule : sccr_pin_sync
`default_nettype wire

//--- hw/sccr_cfg_snapshot.sv
`timescale 1ns/1ps
`default_nettype none
module sccr_cfg_snapshot #(
	parameter int N = 5
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Live and sampled configuration
	sccr_snap_if.snap snap
);
	import sccr_pkg::*;

	// Each slot holds its copy until its own capture or a clear; later edits wait
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_slot
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					snap.active[i] <= SCCR_RST_REG;
				end else if (snap.capture[i]) begin
					snap.active[i] <= snap.live[i];
				end else if (snap.clear) begin
					snap.active[i] <= SCCR_RST_REG;
				end
			end
		end
	endgenerate
endmodule : sccr_cfg_snapshot
`default_nettype wire

//--- hw/sccr_stack_command_control.sv
`timescale 1ns/1ps
`default_nettype none
module sccr_stack_command_control #(
	parameter int RX_SETTLE_CYC = sccr_pkg::SCCR_RX_SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [sccr_pkg::SCCR_ADDR_W-1:0] regAddr,
	input wire logic [sccr_pkg::SCCR_DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [sccr_pkg::SCCR_DATA_W-1:0] regRdData,
	// Address sources
	input wire logic [sccr_pkg::SCCR_ADDR_BITS-1:0] gpioAddrPins,
	input wire logic [sccr_pkg::SCCR_ADDR_BITS-1:0] chainAddr,
	input wire logic chainAddrValid,
	// Wake and hardware chain control
	input wire logic wakeDetect,
	input wire logic [sccr_pkg::SCCR_CHAIN_W-1:0] hwChainEnables,
	// Stack tones and direction
	output logic txOnLowerChain,
	output logic stackShutdownTone,
	output logic stackWakeTone,
	output logic stackResumeTone,
	// Device state
	output sccr_pkg::sccr_mode_t powerMode,
	output logic softResetPulse,
	output logic addressAssignEnable,
	output logic [sccr_pkg::SCCR_ADDR_BITS-1:0] deviceAddress,
	// Chain port enables: upper tx, upper rx, lower tx, lower rx
	output logic [sccr_pkg::SCCR_CHAIN_W-1:0] chainEnables,
	output logic chainRxSettled,
	// Measurement and protection controls
	output logic tempOutEnable,
	output logic thermRefEnable,
	output logic tempCmpEnable,
	output logic voltCmpEnable,
	output logic balancingStart,
	output logic auxConvStart,
	output logic cellConvStart,
	output logic [sccr_pkg::SCCR_NUM_CFG-1:0][sccr_pkg::SCCR_DATA_W-1:0] activeCfg
);
	import sccr_pkg::*;

	logic [7:0] stackCmd;
	logic [7:0] measCtrl;
	logic [7:0] chainManual;
	logic [7:0] addrCfg;
	logic [SCCR_ADDR_BITS-1:0] gpioAddr;
	logic [31:0] settleCount;
	logic rxOnPrev;
	logic wrCmd;
	logic wrMeas;
	logic [7:0] wd;
	logic [7:0] next_rdData;
	logic [SCCR_NUM_CFG-1:0][7:0] cfgLive;

	sccr_snap_if #(.N(SCCR_NUM_CFG), .W(SCCR_DATA_W)) snapBus ();

	// Decode helpers used by several processes
	function automatic logic hit(input logic [SCCR_ADDR_W-1:0] a,
		input logic [SCCR_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	function automatic logic cfgHit(input logic [SCCR_ADDR_W-1:0] a, input int idx);
		cfgHit = (a == SCCR_OFS_CFG_BASE + SCCR_ADDR_W'(idx));
	endfunction : cfgHit

	assign wrCmd = regWr && hit(regAddr, SCCR_OFS_STACK_CMD);
	assign wrMeas = regWr && hit(regAddr, SCCR_OFS_MEAS_CTRL);
	assign wd = regWrData;

	sccr_pin_sync #(.W(SCCR_ADDR_BITS)) u_gpio_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pinIn(gpioAddrPins),
		.pinStable(gpioAddr)
	);

	sccr_cfg_snapshot #(.N(SCCR_NUM_CFG)) u_snapshot (
		.clk_sys(clk_sys),
		.rst(rst),
		.snap(snapBus.snap)
	);

	// Stack command register keeps only the direction bit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stackCmd <= SCCR_RST_REG;
		end else if (wrCmd && !wd[SCCR_B_SOFT_RST]) begin
			stackCmd <= wd & SCCR_STACK_CMD_KEEP;
		end else if (softResetPulse) begin
			stackCmd <= SCCR_RST_REG;
		end
	end

	// Measure and protect register; go bits are never stored
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			measCtrl <= SCCR_RST_REG;
		end else if (wrMeas) begin
			measCtrl <= wd & SCCR_MEAS_CTRL_KEEP;
		end else if (softResetPulse) begin
			measCtrl <= SCCR_RST_REG;
		end
	end

	// Helper registers and live configuration
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chainManual <= SCCR_RST_REG;
			addrCfg <= SCCR_RST_REG;
			cfgLive <= '0;
		end else if (softResetPulse) begin
			chainManual <= SCCR_RST_REG;
			addrCfg <= SCCR_RST_REG;
			cfgLive <= '0;
		end else if (regWr) begin
			if (hit(regAddr, SCCR_OFS_CHAIN_MAN)) begin
				chainManual <= wd;
			end
			if (hit(regAddr, SCCR_OFS_ADDR_CFG)) begin
				addrCfg <= wd;
			end
			for (int i = 0; i < SCCR_NUM_CFG; i++) begin
				if (cfgHit(regAddr, i)) begin
					cfgLive[i] <= wd;
				end
			end
		end
	end

	// One pulse per written one; bits in one write act together
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stackShutdownTone <= 1'b0;
			stackWakeTone <= 1'b0;
			stackResumeTone <= 1'b0;
			softResetPulse <= 1'b0;
			balancingStart <= 1'b0;
			auxConvStart <= 1'b0;
			cellConvStart <= 1'b0;
		end else begin
			stackShutdownTone <= wrCmd && wd[SCCR_B_SHUT_TONE];
			stackWakeTone <= wrCmd && wd[SCCR_B_WAKE_TONE];
			stackResumeTone <= wrCmd && wd[SCCR_B_RESUME_TONE];
			softResetPulse <= wrCmd && wd[SCCR_B_SOFT_RST];
			balancingStart <= wrMeas && wd[SCCR_B_BALANCING_START];
			auxConvStart <= wrMeas && wd[SCCR_B_AUX_GO];
			cellConvStart <= wrMeas && wd[SCCR_B_CELL_GO];
		end
	end

	// Power mode; shutdown outranks sleep when both are written
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			powerMode <= SCCR_ACTIVE;
		end else begin
			case (powerMode)
				SCCR_ACTIVE: begin
					if (wrCmd && wd[SCCR_B_ENTER_SHUT]) begin
						powerMode <= SCCR_SHUTDOWN;
					end else if (wrCmd && wd[SCCR_B_ENTER_SLEEP]) begin
						powerMode <= SCCR_SLEEP;
					end
				end
				SCCR_SLEEP: begin
					if (wrCmd && wd[SCCR_B_ENTER_SHUT]) begin
						powerMode <= SCCR_SHUTDOWN;
					end else if (wakeDetect) begin
						powerMode <= SCCR_ACTIVE;
					end
				end
				SCCR_SHUTDOWN: begin
					if (wakeDetect) begin
						powerMode <= SCCR_ACTIVE;
					end
				end
				default: begin
					powerMode <= SCCR_ACTIVE;
				end
			endcase
		end
	end

	// Address assignment window; a new enable wins over a load that closes it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			addressAssignEnable <= 1'b0;
		end else if (wrCmd && wd[SCCR_B_ADDR_EN]) begin
			addressAssignEnable <= 1'b1;
		end else if (softResetPulse || (chainAddrValid && addressAssignEnable)) begin
			addressAssignEnable <= 1'b0;
		end
	end

	// Address status from GPIO straps or from the chain
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			deviceAddress <= '0;
		end else if (wrCmd && wd[SCCR_B_ADDR_EN] && addrCfg[SCCR_B_GPIO_ADDR_SEL]) begin
			deviceAddress <= gpioAddr;
		end else if (softResetPulse) begin
			deviceAddress <= '0;
		end else if (addressAssignEnable && chainAddrValid
			&& !addrCfg[SCCR_B_GPIO_ADDR_SEL]) begin
			deviceAddress <= chainAddr;
		end
	end

	// Chain port enables, registered so the pins never glitch on a mux swap
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chainEnables <= '0;
		end else if (measCtrl[SCCR_B_CHAIN_MAN]) begin
			chainEnables <= chainManual[SCCR_CHAIN_W-1:0];
		end else begin
			chainEnables <= hwChainEnables;
		end
	end

	// Receiver settle timer; the host must still honour the wait itself
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rxOnPrev <= 1'b0;
			settleCount <= '0;
			chainRxSettled <= 1'b0;
		end else begin
			rxOnPrev <= chainEnables[SCCR_B_UPPER_RX] || chainEnables[SCCR_B_LOWER_RX];
			if (!(chainEnables[SCCR_B_UPPER_RX] || chainEnables[SCCR_B_LOWER_RX])) begin
				settleCount <= '0;
				chainRxSettled <= 1'b0;
			end else if (!rxOnPrev) begin
				settleCount <= '0;
				chainRxSettled <= 1'b0;
			end else if (settleCount < 32'(RX_SETTLE_CYC)) begin
				settleCount <= settleCount + 32'h0000_0001;
			end else begin
				chainRxSettled <= 1'b1;
			end
		end
	end

	// Snapshot triggers: comparators sample on a fresh enable only
	always_comb begin
		snapBus.live = cfgLive;
		snapBus.clear = softResetPulse;
		snapBus.capture = '0;
		snapBus.capture[SCCR_CFG_BAL] = balancingStart;
		snapBus.capture[SCCR_CFG_TEMP] = wrMeas && wd[SCCR_B_TEMP_CMP]
			&& !measCtrl[SCCR_B_TEMP_CMP];
		snapBus.capture[SCCR_CFG_VOLT] = wrMeas && wd[SCCR_B_VOLT_CMP]
			&& !measCtrl[SCCR_B_VOLT_CMP];
		snapBus.capture[SCCR_CFG_AUX] = auxConvStart;
		snapBus.capture[SCCR_CFG_CELL] = auxConvStart || cellConvStart;
	end

	assign activeCfg = snapBus.active;
	assign txOnLowerChain = stackCmd[SCCR_B_DIR];
	assign tempOutEnable = measCtrl[SCCR_B_TEMP_OUT];
	assign thermRefEnable = measCtrl[SCCR_B_TSREF];
	assign tempCmpEnable = measCtrl[SCCR_B_TEMP_CMP];
	assign voltCmpEnable = measCtrl[SCCR_B_VOLT_CMP];

	// Read mux; command bits are not stored so they read zero
	always_comb begin
		next_rdData = SCCR_RD_UNMAPPED;
		if (hit(regAddr, SCCR_OFS_STACK_CMD)) begin
			next_rdData = stackCmd;
		end else if (hit(regAddr, SCCR_OFS_MEAS_CTRL)) begin
			next_rdData = measCtrl;
		end else if (hit(regAddr, SCCR_OFS_CHAIN_MAN)) begin
			next_rdData = chainManual;
		end else if (hit(regAddr, SCCR_OFS_ADDR_CFG)) begin
			next_rdData = addrCfg;
		end else if (hit(regAddr, SCCR_OFS_ADDR_STAT)) begin
			next_rdData = {1'b0, addressAssignEnable, deviceAddress};
		end else if (hit(regAddr, SCCR_OFS_MODE_STAT)) begin
			next_rdData = {4'h0, chainRxSettled, 3'(powerMode)};
		end else begin
			for (int i = 0; i < SCCR_NUM_CFG; i++) begin
				if (cfgHit(regAddr, i)) begin
					next_rdData = cfgLive[i];
				end
			end
		end
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regRdData <= SCCR_RD_UNMAPPED;
		end else if (regRd) begin
			regRdData <= next_rdData;
		end else begin
			regRdData <= SCCR_RD_UNMAPPED;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_dir_follows_write: assert property (wrCmd && !wd[SCCR_B_SOFT_RST] |=>
		txOnLowerChain == $past(wd[SCCR_B_DIR])) else $error("direction not taken");
	a_shut_tone_once: assert property (stackShutdownTone |=> !stackShutdownTone
		|| $past(wrCmd)) else $error("shutdown tone repeated");
	a_wake_tone: assert property (wrCmd && wd[SCCR_B_WAKE_TONE] |=> stackWakeTone)
		else $error("wake tone missing");
	a_resume_tone: assert property (stackResumeTone |-> $past(wrCmd && wd[SCCR_B_RESUME_TONE]))
		else $error("resume tone without write");
	a_enter_shutdown: assert property (wrCmd && wd[SCCR_B_ENTER_SHUT] |=>
		powerMode == SCCR_SHUTDOWN) else $error("shutdown not entered");
	a_enter_sleep: assert property (wrCmd && wd[SCCR_B_ENTER_SLEEP] && !wd[SCCR_B_ENTER_SHUT]
		&& powerMode == SCCR_ACTIVE |=> powerMode == SCCR_SLEEP) else $error("sleep not entered");
	a_soft_reset: assert property (wrCmd && wd[SCCR_B_SOFT_RST] ##2 !regWr |=>
		measCtrl == SCCR_RST_REG && chainManual == SCCR_RST_REG) else $error("soft reset failed");
	a_gpio_address: assert property (wrCmd && wd[SCCR_B_ADDR_EN] && addrCfg[SCCR_B_GPIO_ADDR_SEL]
		|=> deviceAddress == $past(gpioAddr)) else $error("gpio address not loaded");
	a_chain_manual: assert property (measCtrl[SCCR_B_CHAIN_MAN] && !$changed(chainManual)
		|=> chainEnables == $past(chainManual[SCCR_CHAIN_W-1:0])) else $error("manual chain lost");
	a_balance_start: assert property (wrMeas && wd[SCCR_B_BALANCING_START] |=> balancingStart
		##1 activeCfg[SCCR_CFG_BAL] == $past(cfgLive[SCCR_CFG_BAL])) else $error("balance start");
	a_temp_lock: assert property (tempCmpEnable && $past(tempCmpEnable) && !softResetPulse
		|=> $stable(activeCfg[SCCR_CFG_TEMP])) else $error("temperature config changed");
	a_volt_lock: assert property (voltCmpEnable && $past(voltCmpEnable) && !softResetPulse
		|=> $stable(activeCfg[SCCR_CFG_VOLT])) else $error("voltage config changed");
	a_aux_start: assert property (auxConvStart |=>
		activeCfg[SCCR_CFG_AUX] == $past(cfgLive[SCCR_CFG_AUX])) else $error("aux config");
	a_cell_start: assert property (wrMeas && wd[SCCR_B_CELL_GO] |=> cellConvStart ##1
		!cellConvStart || $past(wrMeas)) else $error("cell start");
	a_go_reads_zero: assert property (regRd && hit(regAddr, SCCR_OFS_MEAS_CTRL) |=>
		(regRdData & ~SCCR_MEAS_CTRL_KEEP) == SCCR_RST_REG) else $error("go bit read back");
endmodule : sccr_stack_command_control
`default_nettype wire

//--- verif/sccr_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module sccr_far_side (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Requests from the bench
	input wire logic wakeReq,
	input wire logic sendAddr,
	input wire logic [5:0] offerAddr,
	input wire logic [5:0] pinValue,
	input wire logic [3:0] hwPattern,
	input wire logic chainRxSettled,
	// Lines into the block
	output logic wakeDetect,
	output logic chainAddrValid,
	output logic [5:0] chainAddr,
	output logic [5:0] gpioAddrPins,
	output logic [3:0] hwChainEnables
);
	// Pins, wake and hardware enables follow the bench one cycle late
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wakeDetect <= 1'b0;
			gpioAddrPins <= 6'h00;
			hwChainEnables <= 4'h0;
		end else begin
			wakeDetect <= wakeReq;
			gpioAddrPins <= pinValue;
			hwChainEnables <= hwPattern;
		end
	end
	// No frame before the receiver settles; the word is junk outside valid
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chainAddrValid <= 1'b0;
			chainAddr <= 6'h2A;
		end else begin
			chainAddrValid <= sendAddr & chainRxSettled;
			chainAddr <= sendAddr ? offerAddr : ~chainAddr;
		end
	end
endmodule : sccr_far_side
`default_nettype wire

//--- verif/sccr_stack_command_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module sccr_stack_command_control_test;
	import sccr_pkg::*;
	localparam int SETTLE = 8;
	logic clk_sys, rst, regWr, regRd, wakeDetect, chainAddrValid, sendAddr, wakeReq;
	logic [11:0] regAddr;
	logic [7:0] regWrData, regRdData, rd, v, old;
	logic [5:0] gpioAddrPins, chainAddr, pinValue, offerAddr, deviceAddress;
	logic [3:0] hwChainEnables, hwPattern, chainEnables;
	logic txOnLowerChain, stackShutdownTone, stackWakeTone, stackResumeTone, softResetPulse;
	logic addressAssignEnable, chainRxSettled, tempOutEnable, thermRefEnable;
	logic tempCmpEnable, voltCmpEnable, balancingStart, auxConvStart, cellConvStart;
	sccr_mode_t powerMode;
	logic [SCCR_NUM_CFG-1:0][7:0] activeCfg;
	logic [7:0] live [5];
	int error_cnt = 0;
	int cmp_count = 0;
	sccr_far_side far_u (.clk_sys(clk_sys), .rst(rst), .wakeReq(wakeReq), .sendAddr(sendAddr),
		.offerAddr(offerAddr), .pinValue(pinValue), .hwPattern(hwPattern),
		.chainRxSettled(chainRxSettled), .wakeDetect(wakeDetect),
		.chainAddrValid(chainAddrValid), .chainAddr(chainAddr),
		.gpioAddrPins(gpioAddrPins), .hwChainEnables(hwChainEnables));
	sccr_stack_command_control #(.RX_SETTLE_CYC(SETTLE)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .gpioAddrPins(gpioAddrPins), .chainAddr(chainAddr),
		.chainAddrValid(chainAddrValid), .wakeDetect(wakeDetect),
		.hwChainEnables(hwChainEnables), .txOnLowerChain(txOnLowerChain),
		.stackShutdownTone(stackShutdownTone), .stackWakeTone(stackWakeTone),
		.stackResumeTone(stackResumeTone), .powerMode(powerMode),
		.softResetPulse(softResetPulse), .addressAssignEnable(addressAssignEnable),
		.deviceAddress(deviceAddress), .chainEnables(chainEnables),
		.chainRxSettled(chainRxSettled), .tempOutEnable(tempOutEnable),
		.thermRefEnable(thermRefEnable), .tempCmpEnable(tempCmpEnable),
		.voltCmpEnable(voltCmpEnable), .balancingStart(balancingStart),
		.auxConvStart(auxConvStart), .cellConvStart(cellConvStart), .activeCfg(activeCfg));
	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Only the direction bit survives in the command register
	function automatic logic [7:0] expStack(input logic [7:0] d);
		return {d[SCCR_B_DIR], 7'h00};
	endfunction : expStack
	// Go bits read zero, the rest are stored
	function automatic logic [7:0] expMeas(input logic [7:0] d);
		return d & 8'hDC;
	endfunction : expMeas
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	// One-cycle write; effects are sampled in the cycle after
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rdr(input logic [11:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		rd = regRdData;
	endtask : rdr
	task automatic setLive(input int i);
		live[i] = 8'($urandom);
		wr(SCCR_OFS_CFG_BASE + 12'(i), live[i]);
	endtask : setLive
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		error_cnt++;
		$display("ERROR %0t: watchdog expired", $time);
		end_sim();
	end
	initial begin
		rst = 1'b1;
		{regWr, regRd, sendAddr, wakeReq} = 4'h0;
		regAddr = 12'h000;
		regWrData = 8'h00;
		offerAddr = 6'h00;
		hwPattern = 4'h5;
		void'($urandom(32'h606e));
		pinValue = 6'($urandom);
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rdr(SCCR_OFS_STACK_CMD);
		chk(rd, 8'h00);
		rdr(SCCR_OFS_MEAS_CTRL);
		chk(rd, 8'h00);
		chk(powerMode, SCCR_ACTIVE);
		$display("test reset done");
		// Each tone alone, then all three in one write
		for (int k = 0; k < 4; k++) begin
			v = {1'($urandom), (k < 3) ? (3'b100 >> k) : 3'b111, 4'h0};
			wr(SCCR_OFS_STACK_CMD, v);
			chk({stackShutdownTone, stackWakeTone, stackResumeTone}, v[6:4]);
			chk(txOnLowerChain, v[7]);
			cyc(1);
			chk({stackShutdownTone, stackWakeTone, stackResumeTone}, 3'b000);
			rdr(SCCR_OFS_STACK_CMD);
			chk(rd, expStack(v));
		end
		$display("test tones done");
		wr(SCCR_OFS_STACK_CMD, 8'h04);
		chk(powerMode, SCCR_SLEEP);
		wr(SCCR_OFS_STACK_CMD, 8'h00);
		rdr(SCCR_OFS_MODE_STAT);
		chk(rd[2:0], SCCR_SLEEP);
		wr(SCCR_OFS_STACK_CMD, 8'h08);
		chk(powerMode, SCCR_SHUTDOWN);
		@(posedge clk_sys) wakeReq <= 1'b1;
		@(posedge clk_sys) wakeReq <= 1'b0;
		cyc(3);
		chk(powerMode, SCCR_ACTIVE);
		wr(SCCR_OFS_STACK_CMD, 8'h0C);
		chk(powerMode, SCCR_SHUTDOWN);
		rdr(SCCR_OFS_STACK_CMD);
		chk(rd, 8'h00);
		@(posedge clk_sys) wakeReq <= 1'b1;
		@(posedge clk_sys) wakeReq <= 1'b0;
		$display("test mode done");
		for (int i = 0; i < 5; i++)
			setLive(i);
		rdr(SCCR_OFS_CFG_BASE + 12'h4);
		chk(rd, live[4]);
		wr(SCCR_OFS_MEAS_CTRL, 8'h20);
		chk(balancingStart, 1'b1);
		cyc(1);
		chk({balancingStart, activeCfg[0]}, {1'b0, live[0]});
		old = live[0];
		setLive(0);
		cyc(2);
		chk(activeCfg[0], old);
		wr(SCCR_OFS_MEAS_CTRL, 8'h02);
		chk(auxConvStart, 1'b1);
		cyc(1);
		chk({activeCfg[3], activeCfg[4]}, {live[3], live[4]});
		old = live[3];
		setLive(3);
		setLive(4);
		wr(SCCR_OFS_MEAS_CTRL, 8'h01);
		chk(cellConvStart, 1'b1);
		cyc(1);
		chk({activeCfg[3], activeCfg[4]}, {old, live[4]});
		rdr(SCCR_OFS_MEAS_CTRL);
		chk(rd, 8'h00);
		$display("test snapshot done");
		// Temperature then voltage comparator: lock while enabled
		for (int c = 1; c < 3; c++) begin
			v = (c == 1) ? 8'h08 : 8'h04;
			setLive(c);
			wr(SCCR_OFS_MEAS_CTRL, v);
			cyc(2);
			chk({tempCmpEnable, voltCmpEnable, activeCfg[c]}, {v[3:2], live[c]});
			old = live[c];
			setLive(c);
			wr(SCCR_OFS_MEAS_CTRL, v);
			cyc(2);
			chk(activeCfg[c], old);
			wr(SCCR_OFS_MEAS_CTRL, 8'h00);
			wr(SCCR_OFS_MEAS_CTRL, v);
			cyc(2);
			chk(activeCfg[c], live[c]);
			wr(SCCR_OFS_MEAS_CTRL, 8'h00);
		end
		$display("test compare done");
		chk(chainEnables, hwPattern);
		wr(SCCR_OFS_CHAIN_MAN, 8'h00);
		wr(SCCR_OFS_MEAS_CTRL, 8'h40);
		cyc(3);
		chk({chainEnables, chainRxSettled}, 5'h00);
		v = 8'h04 | (8'($urandom) & 8'h0A);
		wr(SCCR_OFS_CHAIN_MAN, v);
		cyc(4);
		chk({chainEnables, chainRxSettled}, {v[3:0], 1'b0});
		cyc(10);
		chk(chainRxSettled, 1'b1);
		wr(SCCR_OFS_MEAS_CTRL, 8'h00);
		cyc(3);
		chk(chainEnables, hwPattern);
		$display("test chain done");
		wr(SCCR_OFS_ADDR_CFG, 8'h01);
		wr(SCCR_OFS_STACK_CMD, 8'h01);
		chk(addressAssignEnable, 1'b1);
		cyc(1);
		chk(deviceAddress, pinValue);
		rdr(SCCR_OFS_ADDR_STAT);
		chk(rd, {2'b01, pinValue});
		wr(SCCR_OFS_ADDR_CFG, 8'h00);
		wr(SCCR_OFS_STACK_CMD, 8'h01);
		cyc(14);
		// Frames only once the receiver has settled
		@(posedge clk_sys);
		offerAddr <= ~pinValue;
		sendAddr <= chainRxSettled;
		@(posedge clk_sys) sendAddr <= 1'b0;
		cyc(3);
		chk({addressAssignEnable, deviceAddress}, {1'b0, ~pinValue});
		$display("test address done");
		wr(SCCR_OFS_STACK_CMD, 8'h80);
		wr(SCCR_OFS_MEAS_CTRL, 8'h9C);
		chk({tempOutEnable, thermRefEnable}, 2'b11);
		wr(SCCR_OFS_CHAIN_MAN, 8'h0F);
		// Soft reset also drops the temperature output, as the host wants
		wr(SCCR_OFS_STACK_CMD, 8'h82);
		chk(softResetPulse, 1'b1);
		cyc(1);
		chk({softResetPulse, txOnLowerChain, tempOutEnable, activeCfg}, 43'h0);
		for (int i = 0; i < 5; i++) begin
			rdr((i < 2) ? SCCR_OFS_STACK_CMD + 12'(i) : SCCR_OFS_CHAIN_MAN + 12'(i - 2));
			chk(rd, 8'h00);
		end
		$display("test softreset done");
		wr(12'h1FF, 8'hFF);
		rdr(12'h1FF);
		chk(rd, SCCR_RD_UNMAPPED);
		rdr(SCCR_OFS_MEAS_CTRL);
		chk(rd, expMeas(8'h00));
		$display("test unmapped done");
		end_sim();
	end
endmodule : sccr_stack_command_control_test
`default_nettype wire
